// file: iaf_pkg.sv
package iaf_pkg;
   // widths of the data space and of a data byte, slots per port group, most pointers
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int NUM_MODES = 5;
   localparam int MAX_PTR = 4;

   // data-space map of the special registers
   localparam logic [11:0] FLAGS_ADDR = 12'hfd8;
   localparam logic [11:0] PORT_BASE = 12'hfe0;
   localparam logic [11:0] PORT_STRIDE = 12'h008;
   localparam logic [11:0] PTR_LO_OFS = 12'h005;
   localparam logic [11:0] PTR_HI_OFS = 12'h006;

   // apb byte offsets: pointer n at 4*n, flags after the last pointer
   localparam logic [7:0] APB_PTR_OFS = 8'h00;
   localparam logic [7:0] APB_FLAGS_OFS = 8'h10;

   // flag register layout and reset values of the flags and the pointers
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N = 4;
   localparam logic [7:0] FLAGS_MASK = 8'h1f;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [11:0] PTR_RST = 12'h000;

   // access modes, in slot order within a port group
   typedef enum logic [2:0] {
      IAF_PLAIN, IAF_POSTDEC, IAF_POSTINC, IAF_PREINC, IAF_INDEXED
   } iaf_mode_t;

   typedef enum logic [2:0] {
      IAF_ADD, IAF_SUB, IAF_LOGIC, IAF_ROTR, IAF_ROTL
   } iaf_alu_op_t;

   // datapath file access
   typedef struct packed {
      logic valid;
      logic we;
      logic [11:0] addr;
      logic [7:0] wdata;
      logic [7:0] working_register;
   } iaf_req_t;

   // alu flag update
   typedef struct packed {
      logic valid;
      iaf_alu_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] result;
   } iaf_alu_t;

   // resolved data-ram access
   typedef struct packed {
      logic valid;
      logic we;
      logic [11:0] addr;
      logic [7:0] wdata;
   } iaf_mem_t;

   // answer for reads served inside the block
   typedef struct packed {
      logic valid;
      logic zero;
      logic [7:0] rdata;
   } iaf_rsp_t;

   typedef struct packed {
      logic port;
      logic ptr_lo;
      logic ptr_hi;
      logic flags;
      logic [1:0] idx;
      iaf_mode_t mode;
   } iaf_dec_t;
endpackage : iaf_pkg

// file: iaf_core.sv
// Functional notes
// RQ1 - an indirect port access goes to the address held in its pointer
// RQ2 - three 12-bit pointers, each a high and a low byte register
// RQ3 - each pointer has five access slots; the slot chooses pointer update
// RQ4 - post-decrement slot uses the pointer, then lowers it by one
// RQ5 - post-increment slot uses the pointer, then raises it by one
// RQ6 - pre-increment slot raises the pointer first, then uses the new value
// RQ7 - indexed slot adds signed working register to pointer; nothing changes
// RQ8 - pointer steps never touch any arithmetic flag, zero flag included
// RQ9 - steps act on all 12 bits, carrying between low and high byte
// RQ10 - indirect read that lands on a port returns zero and sets zero flag
// RQ11 - indirect write that lands on a port does nothing, flags kept
// RQ12 - a write landing on a pointer byte beats that pointer's step
// RQ13 - flag-affecting op with flag register as target blocks its data write
// RQ14 - top three flag bits are unimplemented and read zero
// RQ15 - negative flag at bit 4 copies result msb
// RQ16 - overflow flag set when signed result flips the sign bit
// RQ17 - zero flag at bit 2 set on zero result, cleared otherwise
// RQ18 - digit carry is nibble carry on add/sub, bit 4 or 3 on rotates
// RQ19 - carry is msb carry on add/sub, low or high bit on rotates
// RQ20 - subtraction adds the two's complement, carries act as inverted borrow
// RQ21 - pointer arithmetic wraps modulo 4096 with no flag raised
`timescale 1ns/1ps
module iaf_core #(
   parameter int NUM_PTR = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire iaf_pkg::iaf_req_t req_i,
   input wire iaf_pkg::iaf_alu_t alu_i,
   output iaf_pkg::iaf_mem_t mem_o,
   output iaf_pkg::iaf_rsp_t rsp_o,
   output logic [7:0] flags_o
);
   import iaf_pkg::*;

   // port groups beyond four would run into the flag slot of the apb map
   if (NUM_PTR < 1 || NUM_PTR > MAX_PTR) begin : g_bad_num_ptr
      $error("NUM_PTR must lie between 1 and 4");
   end

   logic [ADDR_W-1:0] ptr_reg [NUM_PTR]; // RQ2
   logic [ADDR_W-1:0] ptr_next [NUM_PTR];
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   iaf_mem_t mem_reg;
   iaf_mem_t mem_next;
   iaf_rsp_t rsp_reg;
   iaf_rsp_t rsp_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   iaf_dec_t acc_dec;
   iaf_dec_t tgt_dec;
   logic [ADDR_W-1:0] acc_ea;
   logic [ADDR_W-1:0] cur_ptr;
   logic zero_rd;
   logic [8:0] alu_sum;
   logic [4:0] alu_nib;
   logic [7:0] alu_bb;
   logic [7:0] alu_res;
   logic [4:0] alu_flags;
   logic [4:0] alu_touch;

   logic apb_setup;
   logic apb_wr;
   logic apb_flags_hit;
   logic apb_ptr_hit;
   logic [1:0] apb_idx;

   // map a data-space address onto ports, pointer bytes and flags
   function automatic iaf_dec_t decode(input logic [ADDR_W-1:0] a);
      iaf_dec_t d;
      logic [ADDR_W-1:0] base;
      d = '0;
      base = PORT_BASE;
      if (a == FLAGS_ADDR) begin
         d.flags = 1'b1;
      end
      for (int n = 0; n < NUM_PTR; n++) begin
         base = PORT_BASE + 12'(n) * PORT_STRIDE;
         for (int k = 0; k < NUM_MODES; k++) begin
            if (a == base + 12'(k)) begin // RQ3
               d.port = 1'b1;
               d.idx = 2'(n);
               d.mode = iaf_mode_t'(k);
            end
         end
         if (a == base + PTR_LO_OFS) begin
            d.ptr_lo = 1'b1;
            d.idx = 2'(n);
         end
         if (a == base + PTR_HI_OFS) begin
            d.ptr_hi = 1'b1;
            d.idx = 2'(n);
         end
      end
      return d;
   endfunction : decode

   // apb decode; a write lands only at the completing access edge
   assign apb_setup = psel && !penable && !pready_reg;
   assign apb_wr = psel && penable && pready_reg && pwrite && !pslverr_reg;
   assign apb_idx = paddr[3:2];
   assign apb_flags_hit = (paddr == APB_FLAGS_OFS);
   assign apb_ptr_hit = (paddr[7:4] == APB_PTR_OFS[7:4])
      && (paddr[1:0] == 2'b00) && (32'(apb_idx) < NUM_PTR);

   // apb answer: no wait state, read data captured in setup
   always_comb begin
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      if (apb_setup) begin
         pready_next = 1'b1;
         if (apb_flags_hit) begin
            prdata_next = {24'h00_0000, flags_reg};
         end else if (apb_ptr_hit) begin
            prdata_next = 32'(ptr_reg[apb_idx]);
         end else begin
            pslverr_next = 1'b1; // unmapped: error, no effect
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (ce) begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   // alu flag computation; subtract adds the complement plus one
   always_comb begin
      alu_bb = (alu_i.op == IAF_SUB) ? ~alu_i.b : alu_i.b; // RQ20
      alu_sum = {1'b0, alu_i.a} + {1'b0, alu_bb}
         + {8'h00, alu_i.op == IAF_SUB};
      alu_nib = {1'b0, alu_i.a[3:0]} + {1'b0, alu_bb[3:0]}
         + {4'h0, alu_i.op == IAF_SUB};
      alu_res = alu_i.result;
      alu_flags = '0;
      alu_touch = '0;
      alu_touch[FLAG_N] = 1'b1;
      alu_touch[FLAG_Z] = 1'b1;
      unique case (alu_i.op)
         IAF_ADD, IAF_SUB: begin
            alu_res = alu_sum[7:0];
            alu_touch = 5'h1f;
            alu_flags[FLAG_C] = alu_sum[8]; // RQ19
            alu_flags[FLAG_DC] = alu_nib[4]; // RQ18
            alu_flags[FLAG_OV] = (alu_i.a[7] == alu_bb[7])
               && (alu_sum[7] != alu_i.a[7]); // RQ16
         end
         IAF_ROTR: begin
            alu_touch[FLAG_C] = 1'b1;
            alu_touch[FLAG_DC] = 1'b1;
            alu_flags[FLAG_C] = alu_i.a[0]; // RQ19
            alu_flags[FLAG_DC] = alu_i.a[4]; // RQ18
         end
         IAF_ROTL: begin
            alu_touch[FLAG_C] = 1'b1;
            alu_touch[FLAG_DC] = 1'b1;
            alu_flags[FLAG_C] = alu_i.a[7]; // RQ19
            alu_flags[FLAG_DC] = alu_i.a[3]; // RQ18
         end
         IAF_LOGIC: begin
            alu_res = alu_i.result; // logic ops touch n and z only
         end
         default: begin
            alu_touch = '0;
         end
      endcase
      alu_flags[FLAG_N] = alu_res[7]; // RQ15
      alu_flags[FLAG_Z] = (alu_res == 8'h00); // RQ17
   end

   // pointer, flag and access next state; software first, datapath wins
   always_comb begin
      ptr_next = ptr_reg;
      flags_next = flags_reg; // RQ8
      mem_next = '0;
      rsp_next = '0;
      zero_rd = 1'b0;
      acc_dec = decode(req_i.addr);
      cur_ptr = ptr_reg[acc_dec.idx];
      acc_ea = req_i.addr;
      if (apb_wr && apb_flags_hit) begin
         flags_next = pwdata[7:0] & FLAGS_MASK;
      end else if (apb_wr) begin
         ptr_next[apb_idx] = pwdata[ADDR_W-1:0];
      end
      if (req_i.valid && acc_dec.port) begin
         acc_ea = cur_ptr; // RQ1
         unique case (acc_dec.mode)
            IAF_PLAIN: acc_ea = cur_ptr;
            IAF_POSTDEC: ptr_next[acc_dec.idx] = cur_ptr - 12'h001; // RQ4
            IAF_POSTINC: ptr_next[acc_dec.idx] = cur_ptr + 12'h001; // RQ5 RQ21
            IAF_PREINC: begin
               acc_ea = cur_ptr + 12'h001; // RQ6
               ptr_next[acc_dec.idx] = acc_ea; // RQ9
            end
            IAF_INDEXED: begin
               acc_ea = cur_ptr + {{4{req_i.working_register[7]}}, req_i.working_register}; // RQ7
            end
            default: acc_ea = cur_ptr;
         endcase
      end
      // the target is decoded again: a pointer may aim at a special register
      tgt_dec = decode(acc_ea);
      if (req_i.valid) begin
         if (tgt_dec.port) begin // RQ11
            if (!req_i.we) begin
               rsp_next.valid = 1'b1; // RQ10
               rsp_next.zero = 1'b1;
               zero_rd = 1'b1;
            end
         end else if (tgt_dec.ptr_lo) begin
            if (req_i.we) begin
               ptr_next[tgt_dec.idx][7:0] = req_i.wdata; // RQ12
            end else begin
               rsp_next.valid = 1'b1;
               rsp_next.rdata = ptr_reg[tgt_dec.idx][7:0];
            end
         end else if (tgt_dec.ptr_hi) begin
            if (req_i.we) begin
               ptr_next[tgt_dec.idx][ADDR_W-1:8] =
                  req_i.wdata[ADDR_W-9:0]; // RQ12
            end else begin
               rsp_next.valid = 1'b1;
               rsp_next.rdata = 8'(ptr_reg[tgt_dec.idx][ADDR_W-1:8]);
            end
         end else if (tgt_dec.flags) begin
            if (req_i.we) begin
               flags_next = req_i.wdata & FLAGS_MASK; // RQ14
            end else begin
               rsp_next.valid = 1'b1;
               rsp_next.rdata = flags_reg;
            end
         end else begin
            mem_next.valid = 1'b1; // RQ1
            mem_next.we = req_i.we;
            mem_next.addr = acc_ea;
            mem_next.wdata = req_i.wdata;
         end
      end
      // an affecting op overrides any data write to the five flags
      if (alu_i.valid && alu_touch != 5'h00) begin
         if (req_i.valid && req_i.we && tgt_dec.flags) begin
            flags_next = flags_reg; // RQ13
         end
         for (int b = 0; b < 5; b++) begin
            if (alu_touch[b]) begin
               flags_next[b] = alu_flags[b]; // RQ13
            end
         end
      end
      if (zero_rd) begin
         flags_next[FLAG_Z] = 1'b1; // RQ10
      end
      flags_next = flags_next & FLAGS_MASK; // RQ14
   end

   // state registers; ce low freezes everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int n = 0; n < NUM_PTR; n++) begin
            ptr_reg[n] <= PTR_RST;
         end
         flags_reg <= FLAGS_RST;
         mem_reg <= '0;
         rsp_reg <= '0;
      end else if (ce) begin
         ptr_reg <= ptr_next;
         flags_reg <= flags_next;
         mem_reg <= mem_next;
         rsp_reg <= rsp_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign mem_o = mem_reg;
   assign rsp_o = rsp_reg;
   assign flags_o = flags_reg;

   // checks on pointer 0 and the flag register
   logic fire0;
   logic ptr0_wr;
   logic [ADDR_W-1:0] wsext;
   assign fire0 = ce && req_i.valid && acc_dec.port && acc_dec.idx == 2'd0;
   assign ptr0_wr = req_i.valid && req_i.we && tgt_dec.idx == 2'd0
      && (tgt_dec.ptr_lo || tgt_dec.ptr_hi);
   assign wsext = {{4{req_i.working_register[7]}}, req_i.working_register};

   a_postdec_step: assert property (@(posedge pclk) // RQ4
      disable iff (!presetn)
      fire0 && acc_dec.mode == IAF_POSTDEC && !ptr0_wr && !apb_wr
      |=> ptr_reg[0] == $past(ptr_reg[0]) - 12'h001)
      else $error("post-decrement did not lower pointer");

   a_postinc_addr: assert property (@(posedge pclk) // RQ5
      disable iff (!presetn)
      fire0 && acc_dec.mode == IAF_POSTINC && mem_next.valid && !apb_wr
      |=> mem_reg.valid && mem_reg.addr == $past(ptr_reg[0])
         && ptr_reg[0] == $past(ptr_reg[0]) + 12'h001)
      else $error("post-increment address or step wrong");

   a_preinc_addr: assert property (@(posedge pclk) // RQ6
      disable iff (!presetn)
      fire0 && acc_dec.mode == IAF_PREINC && mem_next.valid
      |=> mem_reg.addr == $past(ptr_reg[0]) + 12'h001)
      else $error("pre-increment address wrong");

   a_indexed_addr: assert property (@(posedge pclk) // RQ7
      disable iff (!presetn)
      fire0 && acc_dec.mode == IAF_INDEXED && mem_next.valid && !apb_wr
      |=> mem_reg.addr == $past(ptr_reg[0]) + $past(wsext)
         && ptr_reg[0] == $past(ptr_reg[0]))
      else $error("indexed address wrong or pointer moved");

   a_wrap_top: assert property (@(posedge pclk) // RQ21
      disable iff (!presetn)
      fire0 && acc_dec.mode == IAF_POSTINC && ptr_reg[0] == 12'hfff
      && !ptr0_wr && !apb_wr |=> ptr_reg[0] == 12'h000)
      else $error("pointer did not wrap");

   a_step_no_flags: assert property (@(posedge pclk) // RQ8
      disable iff (!presetn)
      fire0 && mem_next.valid && !alu_i.valid && !apb_wr
      |=> flags_reg == $past(flags_reg))
      else $error("pointer step changed flags");

   a_zero_read: assert property (@(posedge pclk) // RQ10
      disable iff (!presetn)
      ce && req_i.valid && !req_i.we && tgt_dec.port
      |=> rsp_reg.valid && rsp_reg.rdata == 8'h00 && flags_reg[FLAG_Z])
      else $error("port-on-port read not zero");

   a_port_write_nop: assert property (@(posedge pclk) // RQ11
      disable iff (!presetn)
      ce && req_i.valid && req_i.we && tgt_dec.port && !alu_i.valid
      && !apb_wr |=> !mem_reg.valid && $stable(flags_reg))
      else $error("port-on-port write had an effect");

   a_flags_upper: assert property (@(posedge pclk) // RQ14
      disable iff (!presetn)
      flags_o[7:5] == 3'b000)
      else $error("unimplemented flag bits set");

   a_alu_zero: assert property (@(posedge pclk) // RQ17
      disable iff (!presetn)
      ce && alu_i.valid && alu_i.op == IAF_ADD && !zero_rd
      |=> flags_reg[FLAG_Z] == ($past(alu_i.a) + $past(alu_i.b) == 8'h00))
      else $error("zero flag does not follow sum");

   c_postinc: cover property (@(posedge pclk) disable iff (!presetn)
      fire0 && acc_dec.mode == IAF_POSTINC ##1 mem_reg.valid);
   c_zero_read: cover property (@(posedge pclk) disable iff (!presetn)
      ce && zero_rd);
   c_ptr_write_wins: cover property (@(posedge pclk) disable iff (!presetn)
      fire0 && ptr0_wr);
   c_apb_write: cover property (@(posedge pclk) disable iff (!presetn)
      apb_wr && ce);
endmodule : iaf_core

// file: iaf_ram_model.sv
`timescale 1ns/1ps
module iaf_ram_model (
   input wire logic pclk,
   input wire iaf_pkg::iaf_mem_t mem_i,
   output logic [7:0] rdata
);
   import iaf_pkg::*;

   logic [7:0] ram [0:4095];

   // byte-wide data ram; read data one cycle after the access
   // between reads the output toggles each cycle, so a stale byte never holds for two cycles in a row
   always_ff @(posedge pclk) begin
      if (mem_i.valid && mem_i.we) begin
         ram[mem_i.addr] <= mem_i.wdata;
      end
      if (mem_i.valid && !mem_i.we) begin
         rdata <= ram[mem_i.addr];
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule : iaf_ram_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
   import iaf_pkg::*;

   logic pclk = 1'b0;
   logic presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, flags_o, ram_rdata;
   logic [31:0] pwdata, prdata;
   iaf_req_t req;
   iaf_alu_t alu;
   iaf_mem_t mem_o;
   iaf_rsp_t rsp_o;
   int fails = 0;
   int samples_checked = 0;

   always #5 pclk = ~pclk;

   iaf_core #(.NUM_PTR(3)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_i(req),
      .alu_i(alu), .mem_o(mem_o), .rsp_o(rsp_o), .flags_o(flags_o)
   );

   iaf_ram_model ram (.pclk(pclk), .mem_i(mem_o), .rdata(ram_rdata));

   task automatic finish_test;
      if (fails == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; the request stands until pready is seen high or 20 more cycles pass
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1) fails++; // no answer in time
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic ar(input logic [7:0] a, input logic [31:0] e,
      input logic ee);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, e);
      chk(32'(er), 32'(ee));
   endtask : ar

   task automatic aw(input logic [7:0] a, input logic [31:0] d,
      input logic ee);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
      chk(32'(er), 32'(ee));
   endtask : aw

   // one datapath access, then the resolved ram access a cycle later
   task automatic dp(input logic we, input logic [11:0] a,
      input logic [7:0] wd, input logic [7:0] wr, input logic mv,
      input logic [11:0] ma);
      @(posedge pclk);
      req <= '{valid: 1'b1, we: we, addr: a, wdata: wd, working_register: wr};
      @(posedge pclk);
      req.valid <= 1'b0;
      #1;
      chk(32'(mem_o.valid), 32'(mv));
      if (mv) chk(32'({mem_o.we, mem_o.addr}), 32'({we, ma}));
   endtask : dp

   task automatic alu_op(input iaf_alu_op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] r, input logic [7:0] e);
      @(posedge pclk);
      alu <= '{valid: 1'b1, op: op, a: a, b: b, result: r};
      @(posedge pclk);
      alu.valid <= 1'b0;
      #1;
      chk(32'(flags_o), 32'(e));
   endtask : alu_op

   // hang guard, far beyond the roughly 130 cycles the tests take
   initial begin
      #100000;
      fails++;
      finish_test();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      req = '0;
      alu = '0;
      ce = 1'b1;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      ar(8'h10, 32'h0, 1'b0);
      ar(8'h00, 32'h0, 1'b0);
      aw(8'h00, 32'hffff_f123, 1'b0);
      ar(8'h00, 32'h123, 1'b0);
      aw(8'h14, 32'h1, 1'b1);
      ar(8'h14, 32'h0, 1'b1);
      ar(8'h02, 32'h0, 1'b1);
      // each slot of pointer 0 in turn
      dp(1'b0, 12'hfe2, 8'h00, 8'h00, 1'b1, 12'h123);
      ar(8'h00, 32'h124, 1'b0);
      dp(1'b0, 12'hfe1, 8'h00, 8'h00, 1'b1, 12'h124);
      ar(8'h00, 32'h123, 1'b0);
      dp(1'b0, 12'hfe3, 8'h00, 8'h00, 1'b1, 12'h124);
      dp(1'b0, 12'hfe0, 8'h00, 8'h00, 1'b1, 12'h124);
      dp(1'b0, 12'hfe4, 8'h00, 8'hfe, 1'b1, 12'h122);
      dp(1'b0, 12'hfe4, 8'h00, 8'h05, 1'b1, 12'h129);
      ar(8'h00, 32'h124, 1'b0);
      dp(1'b1, 12'hfe2, 8'h5a, 8'h00, 1'b1, 12'h124);
      dp(1'b0, 12'hfe4, 8'h00, 8'hff, 1'b1, 12'h124);
      @(posedge pclk);
      #1;
      chk(32'(ram_rdata), 32'h5a);
      // alu ops: operands, result, flag byte expected after it
      alu_op(IAF_ADD, 8'h7f, 8'h01, 8'h80, 8'h1a);
      alu_op(IAF_LOGIC, 8'h00, 8'h00, 8'h00, 8'h0e);
      alu_op(IAF_SUB, 8'h00, 8'h01, 8'hff, 8'h10);
      alu_op(IAF_SUB, 8'h05, 8'h05, 8'h00, 8'h07);
      alu_op(IAF_ADD, 8'h80, 8'h80, 8'h00, 8'h0d);
      alu_op(IAF_ROTR, 8'h11, 8'h00, 8'h88, 8'h1b);
      alu_op(IAF_ROTL, 8'h88, 8'h00, 8'h10, 8'h0b);
      dp(1'b1, FLAGS_ADDR, 8'hff, 8'h00, 1'b0, 12'h0);
      chk(32'(flags_o), 32'h1f);
      ar(8'h10, 32'h1f, 1'b0);
      // data write and flag-setting op on the flags in the same cycle
      @(posedge pclk);
      req <= '{valid: 1'b1, we: 1'b1, addr: FLAGS_ADDR, wdata: 8'h00,
         working_register: 8'h00};
      alu <= '{valid: 1'b1, op: IAF_LOGIC, a: 8'h0, b: 8'h0, result: 8'h01};
      @(posedge pclk);
      req.valid <= 1'b0;
      alu.valid <= 1'b0;
      #1;
      chk(32'(flags_o), 32'h0b);
      aw(8'h04, 32'hfff, 1'b0);
      dp(1'b0, 12'hfea, 8'h00, 8'h00, 1'b1, 12'hfff);
      ar(8'h04, 32'h0, 1'b0);
      chk(32'(flags_o), 32'h0b);
      aw(8'h04, 32'h0ff, 1'b0);
      dp(1'b0, 12'hfea, 8'h00, 8'h00, 1'b1, 12'h0ff);
      ar(8'h04, 32'h100, 1'b0);
      dp(1'b0, 12'hfe9, 8'h00, 8'h00, 1'b1, 12'h100);
      ar(8'h04, 32'h0ff, 1'b0);
      // pointer 2 aimed at a port of pointer 0, then at a port of pointer 1
      aw(8'h08, 32'hfe2, 1'b0);
      dp(1'b1, 12'hff0, 8'h55, 8'h00, 1'b0, 12'h0);
      chk(32'(rsp_o.valid), 32'h0);
      chk(32'(flags_o), 32'h0b);
      ar(8'h00, 32'h125, 1'b0);
      aw(8'h08, 32'hfe8, 1'b0);
      dp(1'b0, 12'hff0, 8'h00, 8'h00, 1'b0, 12'h0);
      chk(32'({rsp_o.valid, rsp_o.zero, rsp_o.rdata}), 32'h300);
      chk(32'(flags_o), 32'h0f);
      // pointer 0 aimed at its own low byte, written through post-increment
      aw(8'h00, 32'hfe5, 1'b0);
      dp(1'b1, 12'hfe2, 8'h40, 8'h00, 1'b0, 12'h0);
      ar(8'h00, 32'hf40, 1'b0);
      dp(1'b0, 12'hfe6, 8'h00, 8'h00, 1'b0, 12'h0);
      chk(32'({rsp_o.valid, rsp_o.rdata}), 32'h10f);
      // clock enable low: a standing request is neither taken nor stepped
      @(posedge pclk);
      ce <= 1'b0;
      req <= '{valid: 1'b1, we: 1'b0, addr: 12'hfe2, wdata: 8'h00,
         working_register: 8'h00};
      repeat (2) @(posedge pclk);
      req.valid <= 1'b0;
      #1;
      chk(32'(mem_o.valid), 32'h0);
      @(posedge pclk);
      ce <= 1'b1;
      ar(8'h00, 32'hf40, 1'b0);
      // pointer 0 wraps from the top of the data space
      aw(8'h00, 32'hfff, 1'b0);
      dp(1'b0, 12'hfe2, 8'h00, 8'h00, 1'b1, 12'hfff);
      ar(8'h00, 32'h000, 1'b0);
      finish_test();
   end
endmodule : testbench
